// File: common/mcc_pkg.sv
/*
 * mcc_pkg: constants and types for the maintenance console control block.
 * Assumes a single 125 MHz clock domain shared with the bus and sequencer.
 */
package mcc_pkg;
   // register byte offsets on the bus
   localparam logic [5:0] MCC_OFS_STATUS  = 6'h00;
   localparam logic [5:0] MCC_OFS_SWITCH  = 6'h04;
   localparam logic [5:0] MCC_OFS_DKEYS   = 6'h08;
   localparam logic [5:0] MCC_OFS_AKEYS   = 6'h0C;
   localparam logic [5:0] MCC_OFS_SDR     = 6'h10;
   localparam logic [5:0] MCC_OFS_IAR     = 6'h14;
   localparam logic [5:0] MCC_OFS_ERRCAP  = 6'h18;
   // switch register fields
   localparam int MCC_SW_RATE_LO  = 0;   // 2 bits rate
   localparam int MCC_SW_SEL_LO   = 2;   // 2 bits storage select
   localparam int MCC_SW_CMP_LO   = 4;   // 2 bits address compare
   localparam int MCC_SW_PINV     = 6;
   localparam int MCC_SW_REPEAT   = 7;
   localparam int MCC_SW_W        = 8;
   // status register fields
   localparam int MCC_ST_MANUAL   = 0;
   localparam int MCC_ST_RUN      = 1;
   localparam int MCC_ST_LAMP     = 2;
   localparam int MCC_ST_TEST     = 3;
   localparam int MCC_ST_SCLK     = 4;
   // widths
   localparam int MCC_NBTN        = 10;
   localparam int MCC_LAMP_W      = 36;
   localparam int MCC_IAR_W       = 27;
   localparam int MCC_ADR_W       = 24;
   localparam logic [31:0] MCC_BUMP_INIT = 32'h07000000;
   localparam logic [31:0] MCC_ZERO32    = 32'h00000000;
   localparam logic [31:0] MCC_UNMAPPED  = 32'h00000000;

   typedef enum logic [1:0] {
      MCC_RATE_PROC = 2'h0, MCC_RATE_ISTEP = 2'h1, MCC_RATE_SCYC = 2'h2
   } mcc_rate_t;
   typedef enum logic [1:0] {
      MCC_AREA_LOCAL = 2'h0, MCC_AREA_MAIN = 2'h1, MCC_AREA_PROT = 2'h2, MCC_AREA_BUMP = 2'h3
   } mcc_area_t;
   typedef enum logic [1:0] {
      MCC_CMP_PROC = 2'h0, MCC_CMP_STOP = 2'h1, MCC_CMP_SYNC = 2'h2
   } mcc_cmp_t;
   // pushbutton indices
   typedef enum int {
      MCC_B_START = 0, MCC_B_STOP = 1, MCC_B_SYSRST = 2, MCC_B_RESTART = 3,
      MCC_B_CHKRST = 4, MCC_B_SETADR = 5, MCC_B_STORE = 6, MCC_B_DISPLAY = 7,
      MCC_B_LOGOUT = 8, MCC_B_SPARE = 9
   } mcc_btn_t;
   typedef enum logic [4:0] {
      MCC_S_MANUAL = 5'h01, MCC_S_RUN = 5'h02, MCC_S_STOPPING = 5'h04,
      MCC_S_SCSTOP = 5'h08, MCC_S_RESET = 5'h10
   } mcc_state_t;
endpackage : mcc_pkg

// File: src/mcc_console.sv
/*
 * mcc_console: operator/maintenance console control, lamps, keys and
 * pushbutton sequencing toward processor control, storage and channels.
 * Assumes the sequencer acknowledges instruction end, cycle end, wait and
 * load completion with one-cycle pulses on mclk; button and key pins are asynchronous.
 */
// The register offsets and the Avalon-MM register port are this design's own decisions.
// Contract
// - error lamp lit when any trigger set
// - storage data shown on 36 lamps with parity
// - data keys give bytes with good parity
// - parity invert switch flips parity, test light
// - selector routes accesses to four storage areas
// - instruction address shown on 27 lamps
// - address keys form 24-bit storage address
// - instruction step runs one instruction, timer held
// - single cycle steps one clock; switching stops
// - single cycle stop runs no clocks
// - start resumes; after reset uses address register
// - stop at instruction end, interrupts first, manual lamp
// - system reset stops, clears, zeroes address
// - bump reset: first word zero, others 07000000; code zeroes every fourth word of 256
// - restart: reset, load status word, then run
// - check reset clears error capture triggers
// - set address loads keys only in manual
// - store writes data keys only in manual
// - display reads area into proper register
// - log out accepted only in stop states
// - address compare stops, syncs, or idles
// - repeat instruction at key address, test light
`timescale 1ns/1ps
module mcc_console
   import mcc_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   // avalon-mm slave
   input  wire logic [5:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   // console pins
   input  wire logic [MCC_NBTN-1:0]    btn_pins,
   input  wire logic [31:0]            data_key_pins,
   input  wire logic [MCC_ADR_W-1:0]   addr_key_pins,
   // processor control handshakes
   input  wire logic                   insn_end,
   input  wire logic                   cycle_end,
   input  wire logic                   cpu_wait,
   input  wire logic                   intr_taken,
   input  wire logic                   load_done,
   input  wire logic                   hard_stop,
   input  wire logic                   cs_cmp_stop,
   input  wire logic [31:0]            err_set,
   input  wire logic                   iar_step,
   input  wire logic [MCC_ADR_W-1:0]   iar_next,
   input  wire logic                   rd_valid,
   input  wire logic [31:0]            rd_data,
   // processor control outputs
   output logic                        run_cpu,
   output logic                        clk_enable,
   output logic                        halt_loop,
   output logic                        timer_enable,
   output logic                        take_intr,
   output logic                        sys_reset,
   output logic                        load_psw,
   output logic                        logout_req,
   output logic                        scope_sync,
   output logic                        repeat_insn,
   // storage access
   output logic                        sto_wr,
   output logic                        sto_rd,
   output logic      [1:0]             sto_area,
   output logic      [MCC_ADR_W-1:0]   sto_addr,
   output logic      [MCC_LAMP_W-1:0]  sto_wdata,
   // lamps
   output logic                        error_lamp,
   output logic                        manual_lamp,
   output logic                        test_lamp,
   output logic      [MCC_LAMP_W-1:0]  sdr_lamps,
   output logic      [MCC_IAR_W-1:0]   iar_lamps,
   output logic      [31:0]            l_reg,
   output logic      [31:0]            f_reg
);

   // byte parity with optional inversion; odd parity means good
   function automatic logic [MCC_LAMP_W-1:0] pack_par(input logic [31:0] w, input logic inv);
      logic [MCC_LAMP_W-1:0] r;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         r[35 - 9*i]           = ~(^w[31 - 8*i -: 8]) ^ inv;
         r[34 - 9*i -: 8]      = w[31 - 8*i -: 8];
      end
      return r;
   endfunction : pack_par

   // address register lamps: 24 bits with parity after each byte
   function automatic logic [MCC_IAR_W-1:0] iar_par(input logic [MCC_ADR_W-1:0] a);
      logic [MCC_IAR_W-1:0] r;
      r = '0;
      for (int i = 0; i < 3; i++) begin
         r[26 - 9*i]      = ~(^a[23 - 8*i -: 8]);
         r[25 - 9*i -: 8] = a[23 - 8*i -: 8];
      end
      return r;
   endfunction : iar_par

   // two-flop synchronisers for all asynchronous pins
   logic [MCC_NBTN-1:0]  btn_s1_r, btn_s2_r, btn_d_r;
   logic [31:0]          dk_s1_r, dk_r;
   logic [MCC_ADR_W-1:0] ak_s1_r, ak_r;
   always_ff @(posedge mclk) begin
      btn_s1_r <= btn_pins;
      btn_s2_r <= btn_s1_r;
      btn_d_r  <= btn_s2_r;
      dk_s1_r  <= data_key_pins;   // keys may move any time; only synced copy is used
      dk_r     <= dk_s1_r;
      ak_s1_r  <= addr_key_pins;
      ak_r     <= ak_s1_r;
   end

   // one press, one request, by rising-edge detection
   logic [MCC_NBTN-1:0] press;
   genvar g;
   generate
      for (g = 0; g < MCC_NBTN; g++) begin : g_edge
         assign press[g] = btn_s2_r[g] & ~btn_d_r[g];
      end
   endgenerate

   // software switch register
   logic [MCC_SW_W-1:0] sw_r;
   logic [31:0]         errcap_r;
   logic [MCC_ADR_W-1:0] iar_r;
   mcc_state_t          st_r;
   wire mcc_rate_t rate = mcc_rate_t'(sw_r[MCC_SW_RATE_LO +: 2]);
   wire mcc_cmp_t  cmp  = mcc_cmp_t'(sw_r[MCC_SW_CMP_LO +: 2]);
   wire logic      pinv = sw_r[MCC_SW_PINV];
   wire logic      is_manual = (st_r == MCC_S_MANUAL) || (st_r == MCC_S_SCSTOP);
   wire logic      iar_hit = (cmp == MCC_CMP_STOP) && (ak_r == iar_r);

   // avalon slave: one wait cycle then answer
   logic wait_r;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wait_r <= 1'b1;
      end else if ((avs_read || avs_write) && wait_r) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end
   wire logic bus_wr = avs_write && !wait_r;
   wire logic bus_rd = avs_read && !wait_r;
   assign avs_waitrequest = wait_r;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sw_r <= '0;
      end else if (bus_wr && avs_address == MCC_OFS_SWITCH && avs_byteenable[0]) begin
         sw_r <= avs_writedata[MCC_SW_W-1:0];
      end
   end

   // read data mux; outputs registered
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         avs_readdata <= MCC_ZERO32;
      end else if (avs_read && wait_r) begin
         unique case (avs_address)
            MCC_OFS_STATUS: avs_readdata <= {27'h0, ~clk_enable, test_lamp, error_lamp,
                                             run_cpu, manual_lamp};
            MCC_OFS_SWITCH: avs_readdata <= {24'h0, sw_r};
            MCC_OFS_DKEYS:  avs_readdata <= dk_r;
            MCC_OFS_AKEYS:  avs_readdata <= {8'h0, ak_r};
            MCC_OFS_SDR:    avs_readdata <= sdr_lamps[31:0];
            MCC_OFS_IAR:    avs_readdata <= {8'h0, iar_r};
            MCC_OFS_ERRCAP: avs_readdata <= errcap_r;
            default:        avs_readdata <= MCC_UNMAPPED;
         endcase
      end
   end

   // error capture: set wins over check reset
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         errcap_r <= '0;
      end else if (press[MCC_B_CHKRST] || sys_reset) begin
         errcap_r <= err_set;
      end else begin
         errcap_r <= errcap_r | err_set;
      end
   end

   // run state machine
   logic istep_r, restart_r;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_r      <= MCC_S_MANUAL;
         restart_r <= 1'b0;
      end else if (press[MCC_B_SYSRST] || press[MCC_B_RESTART]) begin
         st_r      <= MCC_S_RESET;
         restart_r <= press[MCC_B_RESTART];
      end else begin
         unique case (st_r)
            MCC_S_RESET: begin
               if (!restart_r) st_r <= (rate == MCC_RATE_SCYC) ? MCC_S_SCSTOP : MCC_S_MANUAL;
               else if (load_done) begin
                  st_r      <= MCC_S_RUN;
                  restart_r <= 1'b0;
               end
            end
            MCC_S_MANUAL: if (press[MCC_B_START]) st_r <= MCC_S_RUN;
            MCC_S_SCSTOP: if (press[MCC_B_START]) st_r <= MCC_S_RUN;
            MCC_S_RUN: begin
               if (rate == MCC_RATE_SCYC) st_r <= MCC_S_SCSTOP;
               else if (press[MCC_B_STOP] && cpu_wait) st_r <= MCC_S_MANUAL;
               else if (press[MCC_B_STOP] || istep_r || iar_hit)
                  st_r <= MCC_S_STOPPING;
            end
            MCC_S_STOPPING: if (insn_end || cpu_wait) st_r <= MCC_S_MANUAL;
            default: st_r <= MCC_S_MANUAL;
         endcase
      end
   end

   // instruction step is armed only by a start from a stop, so a mid-run rate move is ignored
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         istep_r <= 1'b0;
      end else if (sys_reset) begin
         istep_r <= 1'b0;
      end else if (press[MCC_B_START] && is_manual) begin
         istep_r <= (rate == MCC_RATE_ISTEP);
      end
   end

   // single-cycle gate: a press in single cycle stop grants one clock step
   logic step_r;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         step_r <= 1'b0;
      end else if (st_r == MCC_S_SCSTOP && press[MCC_B_START]) begin
         step_r <= 1'b1;
      end else if (cycle_end) begin
         step_r <= 1'b0;
      end
   end

   // processor control outputs, all registered
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         run_cpu      <= 1'b0;
         clk_enable   <= 1'b1;
         halt_loop    <= 1'b1;
         timer_enable <= 1'b0;
         take_intr    <= 1'b0;
         sys_reset    <= 1'b0;
         load_psw     <= 1'b0;
         manual_lamp  <= 1'b1;
      end else begin
         run_cpu      <= (st_r == MCC_S_RUN) || (st_r == MCC_S_STOPPING) || step_r;
         clk_enable   <= (st_r != MCC_S_SCSTOP) || step_r;
         halt_loop    <= (st_r == MCC_S_MANUAL) || (st_r == MCC_S_RESET);
         timer_enable <= (st_r == MCC_S_RUN) && (rate != MCC_RATE_ISTEP);
         take_intr    <= (st_r == MCC_S_STOPPING) && !intr_taken;
         sys_reset    <= press[MCC_B_SYSRST] || press[MCC_B_RESTART];
         load_psw     <= (st_r == MCC_S_RESET) && restart_r && !load_done;
         manual_lamp  <= is_manual;
      end
   end

   // instruction address register: reset zero, set from keys, track sequencer
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         iar_r <= '0;
      end else if (sys_reset) begin
         iar_r <= '0;
      end else if (press[MCC_B_SETADR] && is_manual) begin
         iar_r <= ak_r;
      end else if (iar_step && !sw_r[MCC_SW_REPEAT]) begin
         iar_r <= iar_next;
      end
   end

   // storage access: store, display and bump initialisation after reset
   logic [MCC_ADR_W-1:0] bump_ix_r;
   logic                 bump_go_r;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sto_wr    <= 1'b0;
         sto_rd    <= 1'b0;
         sto_area  <= MCC_AREA_LOCAL;
         sto_addr  <= '0;
         sto_wdata <= '0;
         bump_go_r <= 1'b0;
         bump_ix_r <= '0;
      end else if (sys_reset || bump_go_r) begin
         sto_wr    <= 1'b1;
         sto_rd    <= 1'b0;
         sto_area  <= MCC_AREA_BUMP;
         sto_addr  <= sys_reset ? '0 : bump_ix_r;
         // the reset cycle writes word zero itself, so the walk resumes at one
         sto_wdata <= pack_par((sys_reset || bump_ix_r[1:0] == 2'h0) ? MCC_ZERO32
                               : MCC_BUMP_INIT, 1'b0);
         bump_go_r <= sys_reset || !(&bump_ix_r[7:0]);
         bump_ix_r <= sys_reset ? 24'h000001 : bump_ix_r + 1'b1;
      end else begin
         sto_wr    <= press[MCC_B_STORE] && is_manual;
         sto_rd    <= press[MCC_B_DISPLAY] && is_manual;
         sto_area  <= sw_r[MCC_SW_SEL_LO +: 2];
         sto_addr  <= ak_r;
         sto_wdata <= pack_par(dk_r, pinv);
      end
   end

   // display results and lamps
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sdr_lamps  <= '0;
         l_reg      <= '0;
         f_reg      <= '0;
         iar_lamps  <= '0;
         error_lamp <= 1'b0;
         test_lamp  <= 1'b0;
      end else begin
         if (rd_valid) begin
            unique case (mcc_area_t'(sto_area))
               MCC_AREA_LOCAL: l_reg <= rd_data;
               MCC_AREA_PROT:  f_reg <= rd_data;
               default:        sdr_lamps <= pack_par(rd_data, 1'b0);
            endcase
         end
         iar_lamps  <= iar_par(iar_r);
         error_lamp <= |errcap_r;
         test_lamp  <= pinv || (rate != MCC_RATE_PROC) || (cmp != MCC_CMP_PROC)
                       || sw_r[MCC_SW_REPEAT];
      end
   end

   // log out, compare sync pulse and repeat
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         logout_req  <= 1'b0;
         scope_sync  <= 1'b0;
         repeat_insn <= 1'b0;
      end else begin
         logout_req  <= press[MCC_B_LOGOUT] && (is_manual || hard_stop || cs_cmp_stop);
         scope_sync  <= (cmp == MCC_CMP_SYNC) && iar_step && (iar_next == ak_r);
         repeat_insn <= sw_r[MCC_SW_REPEAT];
      end
   end

   // checks
   property p_err_lamp;
      @(posedge mclk) disable iff (!nrst) (|errcap_r) |=> error_lamp;
   endproperty
   a_err_lamp: assert property (p_err_lamp) else $error("error lamp not lit");
   property p_chkrst;
      @(posedge mclk) disable iff (!nrst) (press[MCC_B_CHKRST] && err_set == '0) |=> errcap_r == '0;
   endproperty
   a_chkrst: assert property (p_chkrst) else $error("check reset failed");
   property p_setadr;
      @(posedge mclk) disable iff (!nrst)
         (press[MCC_B_SETADR] && !is_manual && !sys_reset && !iar_step) |=> $stable(iar_r);
   endproperty
   a_setadr: assert property (p_setadr) else $error("set address outside manual");
   property p_store;
      @(posedge mclk) disable iff (!nrst)
         (press[MCC_B_STORE] && !is_manual && !sys_reset && !bump_go_r) |=> !sto_wr;
   endproperty
   a_store: assert property (p_store) else $error("store outside manual");
   property p_reset_iar;
      @(posedge mclk) disable iff (!nrst) sys_reset |=> iar_r == '0;
   endproperty
   a_reset_iar: assert property (p_reset_iar) else $error("iar not zeroed");
   property p_sc_noclk;
      @(posedge mclk) disable iff (!nrst) (st_r == MCC_S_SCSTOP && !step_r) ##1
         (st_r == MCC_S_SCSTOP && !step_r) |-> !clk_enable;
   endproperty
   a_sc_noclk: assert property (p_sc_noclk) else $error("clocks in single cycle stop");
   property p_press_once;
      @(posedge mclk) disable iff (!nrst)
         (press[MCC_B_STORE] && is_manual && !sys_reset && !bump_go_r) |=> sto_wr ##1 !sto_wr;
   endproperty
   a_press_once: assert property (p_press_once) else $error("store press not single");
   property p_parity;
      @(posedge mclk) disable iff (!nrst) (!sys_reset && !bump_go_r) |=>
         (^sto_wdata[35:27]) == !$past(pinv);
   endproperty
   a_parity: assert property (p_parity) else $error("data key parity wrong");
   c_store:   cover property (@(posedge mclk) disable iff (!nrst) sto_wr && is_manual);
   c_restart: cover property (@(posedge mclk) disable iff (!nrst) restart_r && load_done);
   c_scstep:  cover property (@(posedge mclk) disable iff (!nrst) step_r);
endmodule : mcc_console

// File: dv/mcc_partner.sv
/*
 * mcc_partner: behavioural processor control sequencer and storage facing the console.
 * Assumes one mclk domain; read answers alternate between prompt and slow.
 */
`timescale 1ns/1ps
module mcc_partner (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // console requests
   input  wire logic        run_cpu,
   input  wire logic        load_psw,
   input  wire logic        sto_rd,
   // sequencer answers
   output logic             insn_end,
   output logic             load_done,
   output logic             rd_valid,
   output logic [31:0]      rd_data,
   output logic [23:0]      iar_next
);
   logic [2:0] cnt_r;
   logic [2:0] ld_r;
   logic [1:0] rdly_r;
   logic       slow_r;
   // instruction end every eight cycles while running, address moves on each one
   always_ff @(posedge mclk) begin
      cnt_r    <= (nrst && run_cpu) ? cnt_r + 3'h1 : 3'h0;
      insn_end <= nrst && run_cpu && (cnt_r == 3'h7);
      iar_next <= !nrst ? 24'h000000 : (insn_end ? iar_next + 24'h000004 : iar_next);
   end
   // load completes after three cycles of request, pulsed on alternate cycles while all three samples are set
   always_ff @(posedge mclk) begin
      ld_r      <= nrst ? {ld_r[1:0], load_psw} : 3'h0;
      load_done <= nrst && (ld_r == 3'h7) && !load_done;
   end
   // storage read: data wanders outside the valid cycle so stale values never match
   always_ff @(posedge mclk) begin
      if (!nrst || sto_rd) begin
         rdly_r <= (nrst && slow_r) ? 2'h3 : {1'b0, nrst};
         slow_r <= nrst && !slow_r;
      end else if (rdly_r != 2'h0) begin
         rdly_r <= rdly_r - 2'h1;
      end
      rd_valid <= nrst && (rdly_r == 2'h1) && !sto_rd;
      rd_data  <= (rdly_r == 2'h1) ? $urandom : ~rd_data;
   end
endmodule : mcc_partner

// File: dv/mcc_console_bench.sv
/*
 * mcc_console_bench: self-checking bench for the console block with queued expectations.
 * Assumes the partner model answers for sequencer and storage.
 */
`timescale 1ns/1ps
module mcc_console_bench;
   import mcc_pkg::*;
   logic        mclk, nrst, avs_read, avs_write, insn_end, load_done, rd_valid;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, data_key_pins, err_set, rd_data, l_reg, f_reg;
   logic [3:0]  avs_byteenable;
   logic [9:0]  btn_pins;
   logic [23:0] addr_key_pins, iar_next, sto_addr, ak;
   logic [35:0] sto_wdata;
   logic [1:0]  sto_area;
   logic        avs_waitrequest, sto_wr, sto_rd, run_cpu, load_psw, clk_en;
   logic [26:0] iar_lamps;
   logic [63:0] q_rd[$];
   logic [61:0] q_wr[$];
   logic        q_dp[$];
   logic [63:0] e_rd;
   logic [31:0] dd, dk;
   logic        dpend;
   int          n_errors, tests_run, cyc;
   mcc_console u_dut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .btn_pins(btn_pins), .data_key_pins(data_key_pins),
      .addr_key_pins(addr_key_pins), .insn_end(insn_end), .cycle_end(clk_en),
      .cpu_wait(1'b0), .intr_taken(1'b0), .load_done(load_done), .hard_stop(1'b0),
      .cs_cmp_stop(1'b0), .err_set(err_set), .iar_step(insn_end), .iar_next(iar_next),
      .rd_valid(rd_valid), .rd_data(rd_data), .run_cpu(run_cpu), .clk_enable(clk_en),
      .halt_loop(), .timer_enable(), .take_intr(), .sys_reset(), .load_psw(load_psw),
      .logout_req(), .scope_sync(), .repeat_insn(), .sto_wr(sto_wr), .sto_rd(sto_rd),
      .sto_area(sto_area), .sto_addr(sto_addr), .sto_wdata(sto_wdata), .error_lamp(),
      .manual_lamp(), .test_lamp(), .sdr_lamps(), .iar_lamps(iar_lamps), .l_reg(l_reg),
      .f_reg(f_reg));
   mcc_partner u_partner (.mclk(mclk), .nrst(nrst), .run_cpu(run_cpu), .load_psw(load_psw),
      .sto_rd(sto_rd), .insn_end(insn_end), .load_done(load_done), .rd_valid(rd_valid),
      .rd_data(rd_data), .iar_next(iar_next));
   // good parity is odd over each byte plus its parity bit
   function automatic logic [35:0] pw(input logic [31:0] d, input logic inv);
      pw = {~^d[31:24] ^ inv, d[31:24], ~^d[23:16] ^ inv, d[23:16],
            ~^d[15:8] ^ inv, d[15:8], ~^d[7:0] ^ inv, d[7:0]};
   endfunction : pw
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk62(input logic [61:0] got, input logic [61:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk62
   // bus cycle: hold request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      q_rd.push_back({m, e & m});
      bus(1'b0, a, 32'h00000000);
   endtask : rd
   // a press is held long enough to pass the synchroniser, then idles
   task automatic press(input int b);
      @(posedge mclk);
      btn_pins[b] <= 1'b1;
      repeat (6) @(posedge mclk);
      btn_pins[b] <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask : press
   task automatic bump_notes();
      for (int i = 0; i < 256; i++) begin
         q_wr.push_back({2'h3, 24'(i), pw(i % 4 ? MCC_BUMP_INIT : MCC_ZERO32, 1'b0)});
      end
   endtask : bump_notes
   task automatic done(input string s);
      $display("test %s finished, mismatches so far %0d", s, n_errors);
   endtask : done
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // watcher: every result that appears takes the oldest note
   always @(posedge mclk) begin
      cyc++;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         e_rd = q_rd.size() ? q_rd.pop_front() : 'x;
         chk32(avs_readdata & e_rd[63:32], e_rd[31:0]);
      end
      if (sto_wr === 1'b1)
         chk62({sto_area, sto_addr, sto_wdata}, q_wr.size() ? q_wr.pop_front() : 'x);
      if (dpend) chk32(q_dp.pop_front() ? f_reg : l_reg, dd);
      if (rd_valid === 1'b1 && q_dp.size() == 0) chk32(32'hFFFFFFFF, 32'h00000000);
      dpend = rd_valid === 1'b1 && q_dp.size() != 0;
      dd    = rd_data;
      if (cyc == 40000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      {nrst, avs_read, avs_write, btn_pins, err_set, avs_address, avs_writedata} = '0;
      {data_key_pins, addr_key_pins, dpend, cyc, n_errors, tests_run} = '0;
      avs_byteenable = 4'hF;
      void'($urandom(61009));
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      rd(MCC_OFS_STATUS, 32'h0000001F, 32'h00000001);
      rd(6'h3C, 32'hFFFFFFFF, 32'h00000000);
      done("reset");
      // an error trigger lights the lamp, check reset clears it
      dk = 32'h1 << ($urandom % 32);
      err_set <= dk;
      @(posedge mclk);
      err_set <= 32'h00000000;
      rd(MCC_OFS_STATUS, 32'h00000004, 32'h00000004);
      rd(MCC_OFS_ERRCAP, 32'hFFFFFFFF, dk);
      press(MCC_B_CHKRST);
      rd(MCC_OFS_ERRCAP, 32'hFFFFFFFF, 32'h00000000);
      rd(MCC_OFS_STATUS, 32'h00000004, 32'h00000000);
      done("errors");
      // store every area with and without parity inversion
      for (int i = 0; i < 8; i++) begin
         dk = $urandom;
         ak = $urandom;
         data_key_pins <= dk;
         addr_key_pins <= ak;
         bus(1'b1, MCC_OFS_SWITCH, {25'h0, i[2], 2'h0, i[1:0], 2'h0});
         rd(MCC_OFS_STATUS, 32'h00000008, {28'h0, i[2], 3'h0});
         q_wr.push_back({i[1:0], ak, pw(dk, i[2])});
         press(MCC_B_STORE);
      end
      bus(1'b1, MCC_OFS_SWITCH, 32'h00000000);
      done("store");
      // display routes local to the L register and protection to the F register
      for (int i = 0; i < 4; i += 2) begin
         bus(1'b1, MCC_OFS_SWITCH, {28'h0, 2'(i), 2'h0});
         q_dp.push_back(i[1]);
         press(MCC_B_DISPLAY);
      end
      done("display");
      press(MCC_B_SETADR);
      rd(MCC_OFS_IAR, 32'h00FFFFFF, {8'h0, ak});
      chk62(62'(iar_lamps), 62'(pw({8'h00, ak}, 1'b0) & 36'h7FFFFFF));
      bus(1'b1, MCC_OFS_SWITCH, 32'h00000004);
      press(MCC_B_START);
      rd(MCC_OFS_STATUS, 32'h00000003, 32'h00000002);
      bus(1'b1, MCC_OFS_SWITCH, 32'h00000005);
      press(MCC_B_STORE);
      press(MCC_B_SETADR);
      rd(MCC_OFS_STATUS, 32'h00000003, 32'h00000002);
      press(MCC_B_STOP);
      rd(MCC_OFS_STATUS, 32'h00000003, 32'h00000001);
      done("start_stop");
      // instruction step and single cycle both come back to manual
      bus(1'b1, MCC_OFS_SWITCH, 32'h00000001);
      press(MCC_B_START);
      rd(MCC_OFS_STATUS, 32'h00000003, 32'h00000001);
      bus(1'b1, MCC_OFS_SWITCH, 32'h00000002);
      press(MCC_B_START);
      rd(MCC_OFS_STATUS, 32'h00000013, 32'h00000011);
      press(MCC_B_START);
      rd(MCC_OFS_STATUS, 32'h00000013, 32'h00000011);
      bus(1'b1, MCC_OFS_SWITCH, 32'h00000000);
      done("rates");
      // system reset clears errors and address, then initialises bump area
      err_set <= 32'h00000001;
      @(posedge mclk);
      err_set <= 32'h00000000;
      bump_notes();
      press(MCC_B_SYSRST);
      repeat (300) @(posedge mclk);
      rd(MCC_OFS_IAR, 32'h00FFFFFF, 32'h00000000);
      chk62(62'(iar_lamps), 62'(pw(32'h00000000, 1'b0) & 36'h7FFFFFF));
      rd(MCC_OFS_ERRCAP, 32'hFFFFFFFF, 32'h00000000);
      bump_notes();
      press(MCC_B_RESTART);
      repeat (300) @(posedge mclk);
      rd(MCC_OFS_STATUS, 32'h00000003, 32'h00000002);
      press(MCC_B_STOP);
      chk32({31'h0, q_wr.size() == 0}, 32'h00000001);
      done("reset_restart");
      summarize();
   end
endmodule : mcc_console_bench
